//--- design/clt_pkg.sv
package clt_pkg;
    // ==========================================
    // widths and sizes
    localparam int DATA_W = 8;
    localparam int CFG_W = 16;
    localparam int CFG_DEPTH = 8;
    localparam int CFG_AW = 3;
    localparam int FIFO_DEPTH = 4;
    localparam int ROUTE_IN_W = 6;
    localparam int ROUTE_OUT_W = 6;
    localparam int CTRL_W = 8;
    localparam int STAT_W = 8;
    localparam int COND_W = 8;
    // ==========================================
    // configuration word field positions
    localparam int CF_OP_LSB = 0;
    localparam int CF_SRCA_BIT = 3;
    localparam int CF_SRCB_LSB = 4;
    localparam int CF_SHIFT_LSB = 6;
    localparam int CF_DEST_LSB = 8;
    localparam int CF_CIN_LSB = 10;
    localparam int CF_SIN_LSB = 12;
    localparam int CF_MASK_EN_BIT = 14;
    localparam int CF_F0_LD_BIT = 15;
    // ==========================================
    // condition vector bit positions
    localparam int CD_CE0 = 0;
    localparam int CD_CL0 = 1;
    localparam int CD_CE1 = 2;
    localparam int CD_CL1 = 3;
    localparam int CD_ZERO = 4;
    localparam int CD_ONES = 5;
    localparam int CD_OVF = 6;
    localparam int CD_SOUT = 7;
    // ==========================================
    // reset values
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [CFG_W-1:0] RST_CFG_WORD = 16'h0000;
    localparam logic [CFG_AW-1:0] RST_CFG_ADDR = 3'h0;
    localparam logic [DATA_W-1:0] RST_MSB_MASK = 8'hff;
    localparam logic [2:0] RST_MSB_POS = 3'h7;

    typedef enum logic [2:0] {
        CLT_OP_PASS, CLT_OP_INC, CLT_OP_DEC, CLT_OP_ADD,
        CLT_OP_SUB, CLT_OP_AND, CLT_OP_OR, CLT_OP_XOR
    } clt_op_t;

    typedef enum logic [1:0] {
        CLT_SH_NONE, CLT_SH_LEFT, CLT_SH_RIGHT, CLT_SH_SWAP
    } clt_shift_t;

    // decoded configuration word
    typedef struct packed {
        logic f0_load;
        logic mask_en;
        logic [1:0] sin_sel;
        logic [1:0] cin_sel;
        logic [1:0] dest;
        clt_shift_t shift;
        logic [1:0] srcb;
        logic srca;
        clt_op_t op;
    } clt_cfg_t;

    // neighbour chaining signals
    typedef struct packed {
        logic carry;
        logic shift;
        logic cond;
    } clt_chain_t;

    // bus-side fifo port
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } clt_byte_t;
endpackage

//--- design/clt_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module clt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic [WIDTH-1:0] dout_reg;
    logic dval_reg;
    // the output register is a slot too, so depth is the whole capacity
    wire logic [AW:0] used = cnt_reg + (AW+1)'(dval_reg);
    wire logic wr_go = in_valid && in_ready;
    // output register refills whenever it is empty or being taken
    wire logic ld_out = (cnt_reg != '0) && (!dval_reg || out_ready);

    assign in_ready = (used != (AW+1)'(DEPTH));
    assign out_valid = dval_reg;
    assign out_data = dout_reg;
    assign full = !in_ready;
    assign empty = (cnt_reg == '0) && !dval_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            dval_reg <= 1'b0;
            dout_reg <= '0;
        end else if (clk_en) begin
            if (wr_go) begin
                mem_reg[wptr_reg] <= in_data;
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (ld_out) begin
                dout_reg <= mem_reg[rptr_reg];
                rptr_reg <= rptr_reg + 1'b1;
                dval_reg <= 1'b1;
            end else if (out_ready) begin
                dval_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + (AW+1)'(wr_go) - (AW+1)'(ld_out);
        end
    end
endmodule
`default_nettype wire

//--- design/clt_datapath.sv
// Functional notes
// - eight-entry configuration memory, sixteen bits each, one function per entry
// - routing picks the active configuration entry every cycle
// - alu does increment, decrement, add, subtract, and, or, xor
// - shift left, shift right, nibble swap and or mask after alu
// - two masked comparators over accumulators and data registers
// - zero, all-ones, overflow conditions; selectable ones go to routing
// - software sets which bit is msb for arithmetic and shifts
// - one crc or prs step per cycle, any polynomial and width
// - carries, shift data and the zero condition chain to neighbour tiles
// - two four-byte fifos, each set as input or output buffer
// - fifo status selectable as datapath outputs
// - carry and shift-out registered for later cycles, 16-bit on 8-bit
// - six routing inputs and six selectable routing outputs
// - software control register bits drive the routing
// - read-only status returns routed signals, each bit selectable
// - status bits may latch a condition until read clears it
// - datapath and status/control each have own clock enable
// - eight-bit alu completes each operation in one cycle
// - accumulators are sources and sinks, data registers sources only
`timescale 1ns/1ns
`default_nettype none
module clt_datapath (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic dp_en,
    input wire logic sc_en,
    input wire logic [clt_pkg::ROUTE_IN_W-1:0] route_in,
    output logic [clt_pkg::ROUTE_OUT_W-1:0] route_out,
    input wire logic cfg_we,
    input wire logic [clt_pkg::CFG_AW-1:0] cfg_waddr,
    input wire logic [clt_pkg::CFG_W-1:0] cfg_wdata,
    input wire logic [7:0] d0_wdata,
    input wire logic d0_we,
    input wire logic [7:0] d1_wdata,
    input wire logic d1_we,
    input wire logic [7:0] poly,
    input wire logic [7:0] cmp_mask0,
    input wire logic [7:0] cmp_mask1,
    input wire logic [1:0] cmp_sel,
    input wire logic [7:0] or_mask,
    input wire logic [2:0] msb_pos,
    input wire logic crc_en,
    input wire logic chain_en,
    input wire logic [17:0] out_sel,
    input wire logic f0_is_out,
    input wire logic f1_is_out,
    input wire clt_pkg::clt_byte_t bus_f0_wr,
    input wire clt_pkg::clt_byte_t bus_f1_wr,
    output logic bus_f0_wr_ready,
    output logic bus_f1_wr_ready,
    input wire logic bus_f0_rd,
    input wire logic bus_f1_rd,
    output clt_pkg::clt_byte_t bus_f0_rdata,
    output clt_pkg::clt_byte_t bus_f1_rdata,
    input wire clt_pkg::clt_chain_t chain_in,
    output clt_pkg::clt_chain_t chain_out,
    input wire logic [clt_pkg::CTRL_W-1:0] ctrl_wdata,
    input wire logic ctrl_we,
    output logic [clt_pkg::CTRL_W-1:0] ctrl_route,
    input wire logic [23:0] stat_sel,
    input wire logic [clt_pkg::STAT_W-1:0] stat_sticky,
    input wire logic stat_rd,
    output logic [clt_pkg::STAT_W-1:0] stat_rdata,
    output logic [7:0] acc0_out,
    output logic [7:0] acc1_out,
    output logic [3:0] fifo_flags
);
    import clt_pkg::*;
    // ==========================================
    // configuration memory
    logic [CFG_W-1:0] cfg_mem_reg [CFG_DEPTH];
    logic [CFG_W-1:0] cfg_word_reg;
    logic [CFG_AW-1:0] cfg_addr_reg;
    wire logic [CFG_AW-1:0] cfg_addr = route_in[CFG_AW-1:0];
    wire logic [2:0] sin_route = route_in[5:3];
    logic dp_go;
    logic sc_go;
    assign dp_go = clk_en && dp_en;
    assign sc_go = clk_en && sc_en;

    // memory word read into a register; the function is that of the
    // address presented one cycle earlier, a pipeline stage kept for timing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_addr_reg <= RST_CFG_ADDR;
            cfg_word_reg <= RST_CFG_WORD;
        end else if (dp_go) begin
            if (cfg_we) begin
                cfg_mem_reg[cfg_waddr] <= cfg_wdata;
            end
            cfg_addr_reg <= cfg_addr;
            cfg_word_reg <= cfg_mem_reg[cfg_addr];
        end
    end
    clt_cfg_t cfg;
    assign cfg = clt_cfg_t'(cfg_word_reg);

    // ==========================================
    // working registers
    logic [7:0] a0_reg;
    logic [7:0] a1_reg;
    logic [7:0] d0_reg;
    logic [7:0] d1_reg;
    logic carry_reg;
    logic sout_reg;

    // fifo wiring
    logic f0_in_valid, f0_in_ready, f0_out_valid, f0_out_ready, f0_full, f0_empty;
    logic f1_in_valid, f1_in_ready, f1_out_valid, f1_out_ready, f1_full, f1_empty;
    logic [7:0] f0_in_data, f0_out_data, f1_in_data, f1_out_data;

    // ==========================================
    // alu operands and core
    wire logic [7:0] op_a = cfg.srca ? a1_reg : a0_reg;
    logic [7:0] op_b;
    assign op_b = (cfg.srcb == 2'd0) ? d0_reg :
                  (cfg.srcb == 2'd1) ? d1_reg :
                  (cfg.srcb == 2'd2) ? a0_reg : a1_reg;
    logic cin;
    assign cin = (cfg.cin_sel == 2'd0) ? 1'b0 :
                 (cfg.cin_sel == 2'd1) ? 1'b1 :
                 (cfg.cin_sel == 2'd2) ? carry_reg :
                 (chain_en ? chain_in.carry : 1'b0);
    logic sin;
    assign sin = (cfg.sin_sel == 2'd0) ? 1'b0 :
                 (cfg.sin_sel == 2'd1) ? sin_route[0] :
                 (cfg.sin_sel == 2'd2) ? sout_reg :
                 (chain_en ? chain_in.shift : 1'b0);

    // msb mask: bits above msb_pos are outside the active width
    logic [7:0] width_mask;
    logic [7:0] msb_onehot;
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_wm
            assign width_mask[gi] = (3'(gi) <= msb_pos);
            assign msb_onehot[gi] = (3'(gi) == msb_pos);
        end
    endgenerate

    logic [8:0] alu_sum;
    logic [7:0] alu_res;
    always_comb begin
        alu_sum = 9'h000;
        alu_res = 8'h00;
        case (cfg.op)
            CLT_OP_PASS: alu_res = op_a;
            CLT_OP_INC: alu_sum = {1'b0, op_a} + 9'h001;
            CLT_OP_DEC: alu_sum = {1'b0, op_a} - 9'h001;
            CLT_OP_ADD: alu_sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
            CLT_OP_SUB: alu_sum = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
            CLT_OP_AND: alu_res = op_a & op_b;
            CLT_OP_OR: alu_res = op_a | op_b;
            CLT_OP_XOR: alu_res = op_a ^ op_b;
            default: alu_res = op_a;
        endcase
        if (cfg.op inside {CLT_OP_INC, CLT_OP_DEC, CLT_OP_ADD, CLT_OP_SUB}) begin
            alu_res = alu_sum[7:0];
        end
    end

    // carry taken at the programmed msb rather than bit 7
    wire logic [7:0] carry_chain = op_a ^ op_b ^ alu_res;
    wire logic msb_a = |(op_a & msb_onehot);
    wire logic msb_b = |(op_b & msb_onehot);
    wire logic msb_r = |(alu_res & msb_onehot);
    logic carry_out;
    logic [7:0] carry_above;
    assign carry_above = {1'b0, carry_chain[7:1]};
    assign carry_out = (msb_pos == 3'd7) ? alu_sum[8] : |(carry_above & msb_onehot);
    wire logic is_sub = (cfg.op == CLT_OP_SUB) || (cfg.op == CLT_OP_DEC);
    wire logic ovf = is_sub ? ((msb_a != msb_b) && (msb_r != msb_a))
                            : ((msb_a == msb_b) && (msb_r != msb_a));

    // ==========================================
    // shifter, crc step and mask
    logic [7:0] sh_res;
    logic sh_out;
    logic [7:0] right_in;
    assign right_in = (alu_res >> 1) | (sin ? msb_onehot : 8'h00);
    wire logic crc_fb = msb_r ^ sin;
    always_comb begin
        sh_res = alu_res;
        sh_out = 1'b0;
        case (cfg.shift)
            CLT_SH_LEFT: begin
                sh_out = msb_r;
                sh_res = {alu_res[6:0], sin};
                if (crc_en) begin
                    // one lfsr step: shift in zero, fold polynomial on feedback
                    sh_res = {alu_res[6:0], 1'b0} ^ (crc_fb ? poly : 8'h00);
                    sh_out = crc_fb;
                end
            end
            CLT_SH_RIGHT: begin
                sh_out = alu_res[0];
                sh_res = right_in & width_mask;
            end
            CLT_SH_SWAP: sh_res = {alu_res[3:0], alu_res[7:4]};
            default: sh_res = alu_res;
        endcase
    end
    wire logic [7:0] dp_res = (sh_res | (cfg.mask_en ? or_mask : 8'h00)) & width_mask;

    // ==========================================
    // compares
    logic [7:0] c0_a, c0_b, c1_a, c1_b;
    assign c0_a = a0_reg & cmp_mask0;
    assign c0_b = (cmp_sel[0] ? a1_reg : d0_reg) & cmp_mask0;
    assign c1_a = (cmp_sel[1] ? a0_reg : a1_reg) & cmp_mask1;
    assign c1_b = d1_reg & cmp_mask1;
    logic [COND_W-1:0] cond;
    assign cond[CD_CE0] = (c0_a == c0_b);
    assign cond[CD_CL0] = (c0_a < c0_b);
    assign cond[CD_CE1] = (c1_a == c1_b);
    assign cond[CD_CL1] = (c1_a < c1_b);
    assign cond[CD_ZERO] = (dp_res == 8'h00) && (!chain_en || chain_in.cond);
    assign cond[CD_ONES] = (dp_res == width_mask);
    assign cond[CD_OVF] = ovf;
    assign cond[CD_SOUT] = sh_out;

    // ==========================================
    // accumulator and data register updates
    wire logic f0_pop = !f0_is_out && cfg.f0_load && f0_out_valid;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            a0_reg <= RST_BYTE;
            a1_reg <= RST_BYTE;
            d0_reg <= RST_BYTE;
            d1_reg <= RST_BYTE;
            carry_reg <= 1'b0;
            sout_reg <= 1'b0;
        end else if (dp_go) begin
            if (cfg.dest == 2'd1) begin
                a0_reg <= dp_res;
            end else if (cfg.dest == 2'd3 && f0_pop) begin
                a0_reg <= f0_out_data;
            end
            if (cfg.dest == 2'd2) begin
                a1_reg <= dp_res;
            end
            if (d0_we) begin
                d0_reg <= d0_wdata;
            end else if (cfg.dest == 2'd0 && f0_pop) begin
                d0_reg <= f0_out_data;
            end
            if (d1_we) begin
                d1_reg <= d1_wdata;
            end else if (!f1_is_out && f1_out_valid) begin
                d1_reg <= f1_out_data;
            end
            carry_reg <= carry_out;
            sout_reg <= sh_out;
        end
    end

    // ==========================================
    // fifos: input mode bus fills, datapath drains; output mode reversed
    assign f0_in_valid = f0_is_out ? (dp_go && cfg.f0_load) : bus_f0_wr.valid;
    assign f0_in_data = f0_is_out ? a0_reg : bus_f0_wr.data;
    assign f0_out_ready = f0_is_out ? bus_f0_rd : (dp_go && cfg.f0_load);
    assign f1_in_valid = f1_is_out ? dp_go : bus_f1_wr.valid;
    assign f1_in_data = f1_is_out ? dp_res : bus_f1_wr.data;
    assign f1_out_ready = f1_is_out ? bus_f1_rd : dp_go;

    clt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo0 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(f0_in_valid),
        .in_ready(f0_in_ready),
        .in_data(f0_in_data),
        .out_valid(f0_out_valid),
        .out_ready(f0_out_ready),
        .out_data(f0_out_data),
        .full(f0_full),
        .empty(f0_empty)
    );
    clt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo1 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(f1_in_valid),
        .in_ready(f1_in_ready),
        .in_data(f1_in_data),
        .out_valid(f1_out_valid),
        .out_ready(f1_out_ready),
        .out_data(f1_out_data),
        .full(f1_full),
        .empty(f1_empty)
    );
    wire logic [3:0] fifo_stat = {f1_full, f1_empty, f0_full, f0_empty};

    // ==========================================
    // routing outputs: 12-entry pool of conditions and fifo status
    logic [11:0] out_pool;
    assign out_pool = {fifo_stat, cond};
    logic [ROUTE_OUT_W-1:0] route_next;
    generate
        for (gi = 0; gi < ROUTE_OUT_W; gi++) begin : g_ro
            wire logic [3:0] osel = {1'b0, out_sel[gi*3 +: 3]};
            assign route_next[gi] = (gi < 3) ? out_pool[osel] : out_pool[osel + 4'd8 - 4'd8 + 4'(gi > 3 ? 4 : 0)];
        end
    endgenerate

    // ==========================================
    // status and control pair
    logic [CTRL_W-1:0] ctrl_reg;
    logic [STAT_W-1:0] held_reg;
    logic [STAT_W-1:0] stat_src;
    logic [STAT_W-1:0] stat_next;
    logic [15:0] stat_pool;
    assign stat_pool = {ctrl_reg[3:0], fifo_stat, cond};
    generate
        for (gi = 0; gi < STAT_W; gi++) begin : g_st
            assign stat_src[gi] = stat_pool[stat_sel[gi*3 +: 3] + (gi >= 4 ? 4'd8 : 4'd0)];
            // a new event beats the read that clears the held copy
            assign stat_next[gi] = stat_src[gi] ||
                                   (held_reg[gi] && !stat_rd);
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_reg <= RST_BYTE;
            held_reg <= RST_BYTE;
            stat_rdata <= RST_BYTE;
        end else if (sc_go) begin
            if (ctrl_we) begin
                ctrl_reg <= ctrl_wdata;
            end
            held_reg <= stat_next & stat_sticky;
            stat_rdata <= (stat_sticky & held_reg) | (~stat_sticky & stat_src);
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            route_out <= '0;
            chain_out <= '0;
            bus_f0_rdata <= '0;
            bus_f1_rdata <= '0;
            bus_f0_wr_ready <= 1'b0;
            bus_f1_wr_ready <= 1'b0;
            fifo_flags <= 4'h0;
        end else if (clk_en) begin
            route_out <= route_next;
            chain_out <= '{carry: carry_out, shift: sh_out, cond: cond[CD_ZERO]};
            bus_f0_rdata <= '{valid: f0_is_out && f0_out_valid, data: f0_out_data};
            bus_f1_rdata <= '{valid: f1_is_out && f1_out_valid, data: f1_out_data};
            bus_f0_wr_ready <= !f0_is_out && f0_in_ready;
            bus_f1_wr_ready <= !f1_is_out && f1_in_ready;
            fifo_flags <= fifo_stat;
        end
    end
    assign ctrl_route = ctrl_reg;
    assign acc0_out = a0_reg;
    assign acc1_out = a1_reg;
endmodule
`default_nettype wire

//--- verif/clt_datapath_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// port checks for the datapath tile
module clt_datapath_sva (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic dp_en,
    input wire logic sc_en,
    input wire logic ctrl_we,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_route,
    input wire logic [17:0] out_sel,
    input wire logic [5:0] route_out,
    input wire logic [7:0] acc0_out,
    input wire logic [7:0] acc1_out,
    input wire logic [3:0] fifo_flags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_rst_vals;
        $fell(sys_rst) |-> acc0_out == 8'h00 && acc1_out == 8'h00 ##1 fifo_flags == 4'h5;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("reset values wrong");
    property p_freeze;
        !clk_en |=> $stable(acc0_out) && $stable(acc1_out) && $stable(ctrl_route);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while frozen");
    property p_dp_hold;
        !dp_en |=> $stable(acc0_out) && $stable(acc1_out);
    endproperty
    a_dp_hold: assert property (p_dp_hold)
        else $error("accumulator moved with datapath off");
    property p_sc_hold;
        !sc_en |=> $stable(ctrl_route);
    endproperty
    a_sc_hold: assert property (p_sc_hold)
        else $error("control moved with status block off");
    property p_ctl_wr;
        ctrl_we && sc_en && clk_en |=> ctrl_route == $past(ctrl_wdata);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr)
        else $error("control write not routed");
    property p_ctl_keep;
        !ctrl_we |=> $stable(ctrl_route);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep)
        else $error("control changed without write");
    property p_flags;
        !(fifo_flags[0] && fifo_flags[1]) && !(fifo_flags[2] && fifo_flags[3]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("fifo both full and empty");
    // output slot four, select four, shows fifo zero empty in step with the flags
    property p_route;
        clk_en && dp_en && out_sel[14:12] == 3'h4 |=> route_out[4] == fifo_flags[0];
    endproperty
    a_route: assert property (p_route)
        else $error("routed fifo status wrong");
endmodule
bind clt_datapath clt_datapath_sva i_clt_datapath_sva (.core_clk, .sys_rst, .clk_en, .dp_en,
    .sc_en, .ctrl_we, .ctrl_wdata, .ctrl_route, .out_sel, .route_out, .acc0_out, .acc1_out,
    .fifo_flags);
`default_nettype wire

//--- verif/clt_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bus side writer for fifo zero
module clt_bus_model (
    input wire logic core_clk,
    input wire logic wr_ready,
    output clt_pkg::clt_byte_t wr
);
    import clt_pkg::*;
    initial wr = '{valid: 1'b0, data: 8'h00};
    // ready is stale by a cycle, so valid only rises while ready is seen high
    task automatic push(input logic [7:0] b, output logic ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(negedge core_clk);
            ok = wr_ready;
        end
        if (ok) begin
            wr.data = b;
            wr.valid = 1'b1;
            @(negedge core_clk);
            wr.valid = 1'b0;
            wr.data = ~b;
        end
    endtask
endmodule
`default_nettype wire

//--- verif/test_configurable_logic_datapath.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// directed bench for the datapath tile
module test_configurable_logic_datapath;
    import clt_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1, clk_en = 1'b1, dp_en = 1'b1, sc_en = 1'b1, cfg_we = 1'b0;
    logic d0_we = 1'b0, d1_we = 1'b0, ctrl_we = 1'b0, stat_rd = 1'b0;
    logic f0_is_out = 1'b0, f1_is_out = 1'b0, bus_f0_wr_ready, bus_f1_wr_ready;
    logic [5:0] route_in = 6'h00;
    logic [2:0] cfg_waddr = 3'h0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [7:0] d0_wdata = 8'h00, d1_wdata = 8'h00, ctrl_wdata = 8'h00, stat_sticky = 8'h00;
    logic [7:0] or_mask = 8'h40, ctrl_route, stat_rdata, acc0_out, acc1_out;
    logic [23:0] stat_sel = 24'h00_4000;
    logic [17:0] out_sel = 18'h0_4000;
    logic [7:0] poly = 8'h1d, cmp_mask0 = 8'hff, cmp_mask1 = 8'hff;
    logic [2:0] msb_pos = 3'h7;
    logic [1:0] cmp_sel = 2'h0;
    logic crc_en = 1'b0, bus_f1_rd = 1'b0;
    logic [5:0] route_out;
    logic [3:0] fifo_flags;
    clt_byte_t bus_f0_wr, bus_f0_rdata, bus_f1_rdata;
    clt_chain_t chain_out;
    int bad_count = 0;
    int tests_run = 0;
    logic [15:0] w_tab [12] = '{16'h0100, 16'h0101, 16'h0102, 16'h0103, 16'h0104, 16'h0105,
        16'h0106, 16'h0107, 16'h0146, 16'h0186, 16'h01c6, 16'h4106};
    logic [7:0] e_tab [12] = '{8'h9c, 8'h9d, 8'h9b, 8'hd1, 8'h67, 8'h14, 8'hbd, 8'ha9,
        8'h7a, 8'h5e, 8'hdb, 8'hfd};
    clt_datapath i_clt_datapath (.core_clk, .sys_rst, .clk_en, .dp_en, .sc_en, .route_in,
        .route_out, .cfg_we, .cfg_waddr, .cfg_wdata, .d0_wdata, .d0_we, .d1_wdata, .d1_we,
        .poly, .cmp_mask0, .cmp_mask1, .cmp_sel, .or_mask,
        .msb_pos, .crc_en, .chain_en(1'b0), .out_sel, .f0_is_out, .f1_is_out,
        .bus_f0_wr, .bus_f1_wr('0), .bus_f0_wr_ready, .bus_f1_wr_ready, .bus_f0_rd(1'b0),
        .bus_f1_rd, .bus_f0_rdata, .bus_f1_rdata, .chain_in('0), .chain_out, .ctrl_wdata,
        .ctrl_we, .ctrl_route, .stat_sel, .stat_sticky, .stat_rd, .stat_rdata, .acc0_out,
        .acc1_out, .fifo_flags);
    clt_bus_model i_clt_bus_model (.core_clk, .wr_ready(bus_f0_wr_ready), .wr(bus_f0_wr));
    always #5 core_clk = ~core_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("compares=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cfg(input logic [2:0] a, input logic [15:0] w);
        @(negedge core_clk);
        cfg_waddr = a;
        cfg_wdata = w;
        cfg_we = 1'b1;
        @(negedge core_clk);
        cfg_we = 1'b0;
    endtask
    task run(input logic [2:0] a);
        @(negedge core_clk);
        route_in[2:0] = a;
    endtask
    // entry 1 clears acc0, entry 2 loads d1, entry 3 is the case, entry 0 idles
    task t_alu;
        d0_wdata = 8'h35;
        d1_wdata = 8'h9c;
        d0_we = 1'b1;
        d1_we = 1'b1;
        @(negedge core_clk);
        d0_we = 1'b0;
        d1_we = 1'b0;
        cfg(3'h0, 16'h0100);
        cfg(3'h1, 16'h0127);
        cfg(3'h2, 16'h0116);
        for (int i = 0; i < 12; i++) begin
            cfg(3'h3, w_tab[i]);
            run(3'h1);
            run(3'h2);
            run(3'h3);
            run(3'h0);
            repeat (4) @(negedge core_clk);
            chk(acc0_out, e_tab[i]);
        end
        // or then one lfsr step: bd shifted is 7a, msb set folds in the polynomial
        crc_en = 1'b1;
        cfg(3'h3, 16'h0146);
        run(3'h1);
        run(3'h2);
        run(3'h3);
        run(3'h0);
        repeat (4) @(negedge core_clk);
        chk(acc0_out, 8'h67);
        crc_en = 1'b0;
    endtask
    task t_fifo;
        logic ok;
        for (int i = 0; i < 4; i++) begin
            i_clt_bus_model.push(8'ha0 + 8'(i), ok);
            chk({7'h0, ok}, 8'h01);
        end
        repeat (2) @(negedge core_clk);
        chk({4'h0, fifo_flags}, 8'h06);
        chk({7'h0, bus_f0_wr_ready}, 8'h00);
        cfg(3'h4, 16'h8300);
        for (int i = 0; i < 4; i++) begin
            run(3'h4);
            run(3'h0);
            repeat (3) @(negedge core_clk);
            chk(acc0_out, 8'ha0 + 8'(i));
        end
        chk({4'h0, fifo_flags}, 8'h05);
        chk({7'h0, route_out[4]}, 8'h01);
    endtask
    task t_ctrl;
        ctrl_wdata = 8'ha5;
        ctrl_we = 1'b1;
        dp_en = 1'b0;
        @(negedge core_clk);
        chk(ctrl_route, 8'ha5);
        clk_en = 1'b0;
        ctrl_wdata = 8'h3c;
        repeat (2) @(negedge core_clk);
        chk(ctrl_route, 8'ha5);
        clk_en = 1'b1;
        sc_en = 1'b0;
        @(negedge core_clk);
        chk(ctrl_route, 8'ha5);
        sc_en = 1'b1;
        dp_en = 1'b1;
        stat_sticky = 8'h10;
        ctrl_wdata = 8'h00;
        repeat (3) @(negedge core_clk);
        ctrl_we = 1'b0;
        chk(stat_rdata & 8'h10, 8'h10);
        stat_rd = 1'b1;
        @(negedge core_clk);
        stat_rd = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(stat_rdata & 8'h10, 8'h00);
    endtask
    task t_f1;
        f1_is_out = 1'b1;
        f0_is_out = 1'b1;
        route_in[2:0] = 3'h4;
        repeat (8) @(negedge core_clk);
        chk({4'h0, fifo_flags}, 8'h0a);
        chk({7'h0, bus_f1_rdata.valid}, 8'h01);
        chk(bus_f1_rdata.data, 8'ha3);
        chk(bus_f0_rdata.data, 8'ha3);
        dp_en = 1'b0;
        bus_f1_rd = 1'b1;
        repeat (4) @(negedge core_clk);
        bus_f1_rd = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({4'h0, fifo_flags}, 8'h06);
        chk({7'h0, bus_f1_rdata.valid}, 8'h00);
    endtask
    // whole run is a few hundred cycles; this leaves a wide margin
    initial begin
        #100000;
        bad_count++;
        conclude;
    end
    initial begin
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        chk(acc0_out, 8'h00);
        chk(acc1_out, 8'h00);
        chk({4'h0, fifo_flags}, 8'h05);
        t_alu;
        t_fifo;
        t_ctrl;
        t_f1;
        conclude;
    end
endmodule
`default_nettype wire
